/* vsp_sync_pulse_gen.sv */
// Sync pulse generator: counters, blanking strobes, grab strobes, delayed syncs, APB registers
`default_nettype none
module vsp_sync_pulse_gen #(
	parameter int PIX_W = 12,
	parameter int LINE_W = 10
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// External sync pins
	input wire logic ext_vsync_n,
	input wire logic ext_hsync_n,
	// Decoded timing-reference words
	input wire logic trs_strobe,
	input wire logic trs_eav,
	input wire logic trs_field,
	// Internal sync separator
	input wire logic sep_hsync_n,
	input wire logic sep_vsync_n,
	// Timing strobes
	output logic burst_gate_strobe,
	output logic horiz_blank_n,
	output logic vert_blank_n,
	output logic burst_blank_n,
	output logic mixed_blank_n,
	output logic subcarrier_phase_clear,
	output logic field_flag,
	output logic [4:0] line_ident,
	output logic first_half_active,
	output logic second_half_active,
	output logic active_video_out,
	// Grab strobes
	output logic field_match_strobe,
	output logic line_match_strobe,
	output logic pixel_match_strobe,
	// Delayed syncs
	output logic delayed_vsync_out_n,
	output logic delayed_vsync_oe,
	output logic delayed_hsync_out_n,
	output logic delayed_hsync_oe
);
	import vsp_pkg::*;

	if (PIX_W != 12 || LINE_W != 10) begin : g_chk
		$error("vsp_sync_pulse_gen supports PIX_W 12 and LINE_W 10 only");
	end

	// ****************************************
	// Registers
	// ****************************************
	logic [6:0] ctrl_q;
	logic [11:0] line_len_q;
	logic [11:0] burst_pos_q;
	logic [11:0] sav_pos_q;
	logic [11:0] eav_pos_q;
	logic [9:0] grab_line_q;
	logic [2:0] grab_field_q;
	logic [11:0] grab_pix_q;
	logic [31:0] prdata_q;
	logic wr_en;
	logic addr_ok;
	vsp_src_e src;
	vsp_std_e std;
	logic comb3;

	assign src = vsp_src_e'(ctrl_q[CTRL_SRC_LSB +: 2]);
	assign std = vsp_std_e'(ctrl_q[CTRL_STD_LSB +: 2]);
	assign comb3 = ctrl_q[CTRL_COMB3_BIT];

	// Zero wait states; a frozen block holds the bus off rather than losing a write
	assign pready = clk_en;
	assign wr_en = psel & penable & pwrite & clk_en;
	assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_LINE_LEN) || (paddr == OFS_BURST_POS) ||
		(paddr == OFS_SAV_POS) || (paddr == OFS_EAV_POS) || (paddr == OFS_GRAB_FL) ||
		(paddr == OFS_GRAB_PIX) || (paddr == OFS_STATUS) || (paddr == OFS_POSITION);
	assign pslverr = psel & penable & ~addr_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= RST_CTRL;
			line_len_q <= RST_LINE_LEN;
			burst_pos_q <= RST_BURST_POS;
			sav_pos_q <= RST_SAV_POS;
			eav_pos_q <= RST_EAV_POS;
			grab_line_q <= '0;
			grab_field_q <= '0;
			grab_pix_q <= '0;
		end else if (wr_en) begin
			case (paddr)
				OFS_CTRL: ctrl_q <= pwdata[6:0];
				OFS_LINE_LEN: line_len_q <= pwdata[11:0];
				OFS_BURST_POS: burst_pos_q <= pwdata[11:0];
				OFS_SAV_POS: sav_pos_q <= pwdata[11:0];
				OFS_EAV_POS: eav_pos_q <= pwdata[11:0];
				OFS_GRAB_FL: begin
					grab_line_q <= pwdata[9:0];
					grab_field_q <= pwdata[GRAB_FIELD_LSB +: 3];
				end
				OFS_GRAB_PIX: grab_pix_q <= pwdata[11:0];
				default: ;
			endcase
		end
	end

	// ****************************************
	// Reference selection
	// ****************************************
	logic ext_h_lvl;
	logic ext_h_fall;
	logic ext_v_lvl;
	logic ext_v_fall;
	logic sep_h_d1_q;
	logic sep_v_d1_q;
	logic trs_field_q;
	logic href;
	logic vref;
	logic vref_odd;
	logic [11:0] pixel_q;
	logic [9:0] line_q;
	logic [2:0] field_q;

	vsp_pin_sync u_hsync (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.pin_n(ext_hsync_n),
		.level(ext_h_lvl),
		.fall(ext_h_fall)
	);

	vsp_pin_sync u_vsync (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.pin_n(ext_vsync_n),
		.level(ext_v_lvl),
		.fall(ext_v_fall)
	);

	// Separator and timing-word inputs share this clock, so only edge history is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sep_h_d1_q <= 1'b1;
			sep_v_d1_q <= 1'b1;
			trs_field_q <= 1'b0;
		end else if (clk_en) begin
			sep_h_d1_q <= sep_hsync_n;
			sep_v_d1_q <= sep_vsync_n;
			if (trs_strobe && trs_eav) begin
				trs_field_q <= trs_field;
			end
		end
	end

	always_comb begin
		href = 1'b0;
		vref = 1'b0;
		vref_odd = 1'b0;
		case (src)
			VSP_SRC_EXT: begin
				href = ext_h_fall;
				vref = ext_v_fall;
				vref_odd = ext_v_fall & ~ext_h_fall & (pixel_q >= VS_EDGE_MIN_CLKS);
			end
			VSP_SRC_TRS: begin
				href = trs_strobe & trs_eav;
				vref = href & (trs_field != trs_field_q);
				vref_odd = trs_field;
			end
			VSP_SRC_SEP: begin
				href = sep_h_d1_q & ~sep_hsync_n;
				vref = sep_v_d1_q & ~sep_vsync_n;
				vref_odd = vref & ~href & (pixel_q >= VS_EDGE_MIN_CLKS);
			end
			default: ;
		endcase
	end

	// ****************************************
	// Pixel, line and field counters
	// ****************************************
	logic vpend_q;
	logic vodd_q;
	logic line_end;
	logic [9:0] last_line;
	logic [9:0] first_line;
	logic [2:0] field_mask;
	logic [2:0] field_inc;

	assign last_line = ((std == VSP_STD_PAL) ? LAST_LINE_625 : LAST_LINE_525) + {9'h000, field_q[0]};
	assign field_mask = (std == VSP_STD_PAL) ? 3'h7 : 3'h3;
	assign field_inc = (field_q + 3'h1) & field_mask;
	assign first_line = comb3 ? 10'h001 : 10'h000;
	// Flywheel keeps counting when a reference goes missing
	assign line_end = href || (pixel_q >= line_len_q - 12'h001);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vpend_q <= 1'b0;
			vodd_q <= 1'b0;
		end else if (clk_en) begin
			// A reference on a line end is taken at once, not again one line later
			if (vref && !line_end) begin
				vpend_q <= 1'b1;
				vodd_q <= vref_odd;
			end else if (line_end) begin
				vpend_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pixel_q <= '0;
			line_q <= '0;
			field_q <= '0;
		end else if (clk_en) begin
			if (line_end) begin
				pixel_q <= '0;
				if (vpend_q || vref) begin
					line_q <= first_line;
					field_q <= {field_inc[2:1], (vref ? vref_odd : vodd_q)} & field_mask;
				end else if (line_q >= last_line) begin
					line_q <= '0;
					field_q <= field_inc;
				end else begin
					line_q <= line_q + 10'h001;
				end
			end else begin
				pixel_q <= pixel_q + 12'h001;
			end
		end
	end

	// ****************************************
	// Line decode tables
	// ****************************************
	// line ident
	function automatic logic [4:0] ident_of(input logic [9:0] ln);
		logic [4:0] id;
		id = 5'h17;
		if (ln == 10'd0) id = 5'h00;
		else if (ln <= 10'd4) id = 5'h01;
		else if (ln <= 10'd8) id = 5'(ln - 10'd3);
		else if (ln <= 10'd16) id = 5'h06;
		else if (ln <= 10'd18) id = 5'(ln - 10'd10);
		else if (ln <= 10'd21) id = 5'h09;
		else if (ln <= 10'd24) id = 5'(ln - 10'd12);
		else if (ln <= 10'd257) id = 5'h0D;
		else if (ln <= 10'd259) id = 5'(ln - 10'd244);
		else if (ln <= 10'd261) id = 5'h10;
		else if (ln == 10'd262) id = 5'h11;
		else if (ln <= 10'd307) id = 5'h12;
		else if (ln <= 10'd312) id = 5'(ln - 10'd289);
		return id;
	endfunction

	// Returns 1 on blanked lines
	function automatic logic vblank_of(input vsp_std_e sd, input logic odd, input logic [9:0] ln);
		logic b;
		b = 1'b0;
		if (sd == VSP_STD_PAL) begin
			b = odd ? (ln <= 10'd22 || ln == 10'd311 || ln == 10'd312) : (ln <= 10'd21 || ln == 10'd310 || ln == 10'd311);
		end else if (sd == VSP_STD_PALM && odd) begin
			b = ln <= 10'd6 || ln == 10'd260 || ln == 10'd262;
		end else begin
			b = odd ? (ln <= 10'd6 || (ln >= 10'd260 && ln <= 10'd262)) : (ln <= 10'd5 || ln == 10'd260 || ln == 10'd261);
		end
		return b;
	endfunction

	function automatic logic bblank_of(input vsp_std_e sd, input logic [2:0] fd, input logic [9:0] ln);
		logic b;
		b = 1'b0;
		case (sd)
			VSP_STD_PAL: begin
				case (fd[1:0])
					2'd0: b = ln <= 10'd5 || (ln >= 10'd309 && ln <= 10'd311);
					2'd1: b = ln <= 10'd5 || (ln >= 10'd309 && ln <= 10'd312);
					2'd2: b = ln <= 10'd4 || ln == 10'd310 || ln == 10'd311;
					default: b = ln <= 10'd6 || (ln >= 10'd310 && ln <= 10'd312);
				endcase
			end
			VSP_STD_PALM: begin
				case (fd[1:0])
					2'd0: b = ln <= 10'd7 || (ln >= 10'd259 && ln <= 10'd261);
					2'd1: b = ln <= 10'd7 || (ln >= 10'd259 && ln <= 10'd262);
					2'd2: b = ln <= 10'd6 || ln == 10'd258 || ln == 10'd261;
					default: b = ln <= 10'd6 || (ln >= 10'd260 && ln <= 10'd262);
				endcase
			end
			default: begin
				b = fd[0] ? (ln <= 10'd6 || (ln >= 10'd260 && ln <= 10'd262))
					: (ln <= 10'd5 || (ln >= 10'd259 && ln <= 10'd261));
			end
		endcase
		return b;
	endfunction

	// ****************************************
	// Strobe decode
	// ****************************************
	logic in_active;
	logic in_av;
	logic vblank;
	logic mid_extra;
	logic [12:0] mid_pos;
	logic [12:0] av_end;
	logic [11:0] dvs_line;
	logic [6:0] dhs_cnt_q;

	assign in_active = (pixel_q >= sav_pos_q) && (pixel_q <= eav_pos_q);
	assign mid_pos = ({1'b0, sav_pos_q} + {1'b0, eav_pos_q}) >> 1;
	// widened span, clipped at line start
	assign av_end = {1'b0, eav_pos_q} + {1'b0, AV_LEAD_CLKS};
	assign in_av = ({1'b0, pixel_q} + {1'b0, AV_LEAD_CLKS} >= {1'b0, sav_pos_q}) && ({1'b0, pixel_q} <= av_end);
	assign vblank = vblank_of(std, field_q[0], line_q);
	assign mid_extra = (std == VSP_STD_PAL)
		? (line_q == 10'd310 && in_active && {1'b0, pixel_q} < mid_pos && field_q[0])
		: (line_q == 10'd259 && in_active && {1'b0, pixel_q} >= mid_pos && !field_q[0]);
	// the sync line trails the internal numbering by the comb delay
	assign dvs_line = {2'b00, first_line};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			burst_gate_strobe <= 1'b0;
			horiz_blank_n <= 1'b1;
			vert_blank_n <= 1'b1;
			burst_blank_n <= 1'b1;
			mixed_blank_n <= 1'b1;
			subcarrier_phase_clear <= 1'b0;
			field_flag <= 1'b0;
			line_ident <= 5'h00;
			first_half_active <= 1'b0;
			second_half_active <= 1'b0;
			active_video_out <= 1'b0;
		end else if (clk_en) begin
			burst_gate_strobe <= (pixel_q >= burst_pos_q) && (pixel_q < burst_pos_q + BURST_GATE_CLKS);
			horiz_blank_n <= ~in_active;
			vert_blank_n <= ~vblank;
			burst_blank_n <= ~bblank_of(std, field_q, line_q);
			mixed_blank_n <= ~in_active & ~vblank & ~mid_extra;
			// phase offset cleared while horizontal blank low
			subcarrier_phase_clear <= in_active;
			field_flag <= field_q[0];
			line_ident <= ident_of(line_q);
			first_half_active <= in_active && !vblank && {1'b0, pixel_q} < mid_pos;
			second_half_active <= in_active && !vblank && {1'b0, pixel_q} >= mid_pos;
			active_video_out <= in_av;
		end
	end

	// ****************************************
	// Grab strobes and delayed syncs
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			field_match_strobe <= 1'b0;
			line_match_strobe <= 1'b0;
			pixel_match_strobe <= 1'b0;
			delayed_vsync_out_n <= 1'b1;
			delayed_hsync_out_n <= 1'b1;
			dhs_cnt_q <= 7'(DELAYED_HSYNC_OUT_CLKS);
		end else if (clk_en) begin
			// field and line matches, forced high for every-line grab_trigger
			field_match_strobe <= ctrl_q[CTRL_GRAB_ALL_BIT] || (field_q == grab_field_q);
			line_match_strobe <= ctrl_q[CTRL_GRAB_ALL_BIT] || (line_q == grab_line_q);
			pixel_match_strobe <= pixel_q == grab_pix_q;
			delayed_vsync_out_n <= ~({2'b00, line_q} == dvs_line);
			delayed_hsync_out_n <= (dhs_cnt_q == 7'h00);
			// A reference inside a running pulse does not stretch it; that line's pulse is dropped
			if (line_end && dhs_cnt_q == 7'h00) begin
				dhs_cnt_q <= 7'(DELAYED_HSYNC_OUT_CLKS);
			end else if (dhs_cnt_q != 7'h00) begin
				dhs_cnt_q <= dhs_cnt_q - 7'h01;
			end
		end
	end

	// drive only while disable bit low
	assign delayed_vsync_oe = ~ctrl_q[CTRL_SYNC_DIS_BIT];
	assign delayed_hsync_oe = ~ctrl_q[CTRL_SYNC_DIS_BIT];

	// ****************************************
	// Read data, captured in the setup cycle
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (clk_en && psel && !penable) begin
			prdata_q <= 32'h0000_0000;
			case (paddr)
				OFS_CTRL: prdata_q[6:0] <= ctrl_q;
				OFS_LINE_LEN: prdata_q[11:0] <= line_len_q;
				OFS_BURST_POS: prdata_q[11:0] <= burst_pos_q;
				OFS_SAV_POS: prdata_q[11:0] <= sav_pos_q;
				OFS_EAV_POS: prdata_q[11:0] <= eav_pos_q;
				OFS_GRAB_FL: prdata_q <= {13'h0000, grab_field_q, 6'h00, grab_line_q};
				OFS_GRAB_PIX: prdata_q[11:0] <= grab_pix_q;
				OFS_STATUS: prdata_q <= {19'h0_0000, ext_v_lvl, ext_h_lvl, line_ident, field_flag,
					vert_blank_n, horiz_blank_n, field_match_strobe, line_match_strobe, pixel_match_strobe};
				OFS_POSITION: begin
					prdata_q[11:0] <= pixel_q;
					prdata_q[POS_LINE_LSB +: 10] <= line_q;
					prdata_q[POS_FIELD_LSB +: 3] <= field_q;
				end
				default: ;
			endcase
		end
	end

	assign prdata = prdata_q;
endmodule // vsp_sync_pulse_gen
`default_nettype wire

/* vsp_pkg.sv */
// Constants, register map and enumerations for the video sync pulse generator
`default_nettype none
package vsp_pkg;
	// ****************************************
	// Register map (byte offsets)
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_LINE_LEN = 8'h04;
	localparam logic [7:0] OFS_BURST_POS = 8'h08;
	localparam logic [7:0] OFS_SAV_POS = 8'h0C;
	localparam logic [7:0] OFS_EAV_POS = 8'h10;
	localparam logic [7:0] OFS_GRAB_FL = 8'h14;
	localparam logic [7:0] OFS_GRAB_PIX = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;
	localparam logic [7:0] OFS_POSITION = 8'h20;
	// ****************************************
	// Control fields
	// ****************************************
	localparam int CTRL_SRC_LSB = 0;
	localparam int CTRL_STD_LSB = 2;
	localparam int CTRL_COMB3_BIT = 4;
	localparam int CTRL_SYNC_DIS_BIT = 5;
	localparam int CTRL_GRAB_ALL_BIT = 6;
	localparam int GRAB_FIELD_LSB = 16;
	localparam int POS_LINE_LSB = 16;
	localparam int POS_FIELD_LSB = 28;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [6:0] RST_CTRL = 7'h00;
	localparam logic [11:0] RST_LINE_LEN = 12'h035A;
	localparam logic [11:0] RST_BURST_POS = 12'h0013;
	localparam logic [11:0] RST_SAV_POS = 12'h007A;
	localparam logic [11:0] RST_EAV_POS = 12'h0352;
	// ****************************************
	// Cycle counts
	// ****************************************
	localparam logic [11:0] BURST_GATE_CLKS = 12'h0010;
	localparam logic [11:0] DELAYED_HSYNC_OUT_CLKS = 12'h0040;
	localparam logic [11:0] AV_LEAD_CLKS = 12'h0004;
	localparam logic [11:0] VS_EDGE_MIN_CLKS = 12'h0002;
	// ****************************************
	// Last line numbers of an even field
	// ****************************************
	localparam logic [9:0] LAST_LINE_525 = 10'h105;
	localparam logic [9:0] LAST_LINE_625 = 10'h137;
	// ****************************************
	// Enumerations
	// ****************************************
	typedef enum logic [1:0] {
		VSP_SRC_EXT = 2'b00,
		VSP_SRC_TRS = 2'b01,
		VSP_SRC_SEP = 2'b10
	} vsp_src_e;
	typedef enum logic [1:0] {
		VSP_STD_NTSC = 2'b00,
		VSP_STD_PAL = 2'b01,
		VSP_STD_PALM = 2'b10
	} vsp_std_e;
endpackage
`default_nettype wire

/* vsp_pin_sync.sv */
// Three-stage pin synchroniser with falling-edge event
`default_nettype none
module vsp_pin_sync (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Pin and result
	input wire logic pin_n,
	output logic level,
	output logic fall
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;

	// First stage feeds only the second; a change counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			level_q <= 1'b1;
		end else if (clk_en) begin
			s1_q <= pin_n;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end

	assign level = level_q;
	assign fall = level_q & (s2_q == s3_q) & ~s3_q;
endmodule // vsp_pin_sync
`default_nettype wire

/* vsp_encoder_model.sv */
// Downstream encoder model: resolves the delayed sync pins and measures the hsync pulse width
`default_nettype none
module vsp_encoder_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Delayed sync pins from the generator
	input wire logic hs_out_n,
	input wire logic hs_oe,
	input wire logic vs_out_n,
	input wire logic vs_oe,
	// Resolved pins and measurement
	output logic hs_wire,
	output logic vs_wire,
	output logic [7:0] hs_width
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] cnt_q;
	assign hs_wire = hs_oe ? hs_out_n : 1'b1;
	assign vs_wire = vs_oe ? vs_out_n : 1'b1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 8'h00;
			hs_width <= 8'h00;
		end else if (!hs_wire) begin
			cnt_q <= cnt_q + 8'h01;
		end else begin
			if (cnt_q != 8'h00) begin
				hs_width <= cnt_q;
			end
			cnt_q <= 8'h00;
		end
	end
endmodule // vsp_encoder_model
`default_nettype wire

/* vsp_sync_monitor.sv */
// Port checker for the sync pulse generator
`default_nettype none
module vsp_sync_monitor import vsp_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// Strobes
	input wire logic burst_gate_strobe,
	input wire logic horiz_blank_n,
	input wire logic vert_blank_n,
	input wire logic mixed_blank_n,
	input wire logic subcarrier_phase_clear,
	input wire logic first_half_active,
	input wire logic second_half_active,
	input wire logic active_video_out,
	// Delayed syncs
	input wire logic delayed_hsync_out_n,
	input wire logic delayed_hsync_oe,
	input wire logic delayed_vsync_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] hs_cnt_q;
	logic [7:0] bg_cnt_q;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Run lengths; a restart may cut a pulse short, so only overlong ones are flagged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_cnt_q <= 8'h00;
		end else begin
			hs_cnt_q <= delayed_hsync_out_n ? 8'h00 : hs_cnt_q + 8'h01;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bg_cnt_q <= 8'h00;
		end else begin
			bg_cnt_q <= burst_gate_strobe ? bg_cnt_q + 8'h01 : 8'h00;
		end
	end
	phase_clear_a: assert property (subcarrier_phase_clear == !horiz_blank_n)
		else $error("phase clear does not follow horizontal blank");
	mix_horiz_a: assert property (!horiz_blank_n |-> !mixed_blank_n)
		else $error("mixed blank missed horizontal blank");
	mix_vert_a: assert property (!vert_blank_n |-> !mixed_blank_n)
		else $error("mixed blank missed vertical blank");
	half_excl_a: assert property (!(first_half_active && second_half_active))
		else $error("both half flags high");
	half_vblank_a: assert property (!vert_blank_n |-> !first_half_active && !second_half_active)
		else $error("half flag during vertical blank");
	half_span_a: assert property (second_half_active |-> !horiz_blank_n)
		else $error("second half flag outside active span");
	av_span_a: assert property (!horiz_blank_n |-> active_video_out)
		else $error("active video low inside active span");
	av_lead_a: assert property ($fell(horiz_blank_n) |-> $past(active_video_out, 4) && !$past(active_video_out, 5))
		else $error("active video lead is not four clocks");
	sync_oe_a: assert property (psel && penable && pready && pwrite && paddr == OFS_CTRL
		|=> delayed_hsync_oe == !$past(pwdata[5]) && delayed_vsync_oe == !$past(pwdata[5]))
		else $error("sync output enable does not follow control bit");
	hs_len_a: assert property (hs_cnt_q <= 8'h40)
		else $error("delayed hsync longer than 64 clocks");
	gate_len_a: assert property (bg_cnt_q <= 8'h10)
		else $error("burst gate longer than 16 clocks");
endmodule // vsp_sync_monitor
bind vsp_sync_pulse_gen vsp_sync_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.burst_gate_strobe, .horiz_blank_n, .vert_blank_n, .mixed_blank_n, .subcarrier_phase_clear,
	.first_half_active, .second_half_active, .active_video_out, .delayed_hsync_out_n,
	.delayed_hsync_oe, .delayed_vsync_oe);
`default_nettype wire

/* video_sync_pulse_generator_test.sv */
// Testbench for the sync pulse generator
`default_nettype none
module video_sync_pulse_generator_test;
	timeunit 1ns;
	timeprecision 100ps;
	import vsp_pkg::*;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, hsync_drv_n, vsync_drv_n;
	logic trs_strobe, trs_eav, trs_field, hs_wire, burst_gate_strobe, horiz_blank_n, vert_blank_n;
	logic burst_blank_n, mixed_blank_n, subcarrier_phase_clear, field_flag, first_half_active;
	logic second_half_active, active_video_out, field_match_strobe, line_match_strobe, pixel_match_strobe;
	logic delayed_vsync_out_n, delayed_vsync_oe, delayed_hsync_out_n, delayed_hsync_oe;
	logic [7:0] paddr, hs_width;
	logic [31:0] pwdata, prdata, r;
	logic [4:0] line_ident;
	logic e;
	int err_total, n_checks, cyc;
	logic [7:0] ofs [5] = '{OFS_CTRL, OFS_LINE_LEN, OFS_BURST_POS, OFS_SAV_POS, OFS_EAV_POS};
	logic [31:0] rstv [5] = '{32'h0000_0000, 32'h0000_035A, 32'h0000_0013, 32'h0000_007A, 32'h0000_0352};
	vsp_sync_pulse_gen dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .ext_vsync_n(vsync_drv_n), .ext_hsync_n(hsync_drv_n), .trs_strobe, .trs_eav,
		.trs_field, .sep_hsync_n(hsync_drv_n), .sep_vsync_n(vsync_drv_n), .burst_gate_strobe, .horiz_blank_n,
		.vert_blank_n, .burst_blank_n, .mixed_blank_n, .subcarrier_phase_clear, .field_flag, .line_ident,
		.first_half_active, .second_half_active, .active_video_out, .field_match_strobe, .line_match_strobe,
		.pixel_match_strobe, .delayed_vsync_out_n, .delayed_vsync_oe, .delayed_hsync_out_n, .delayed_hsync_oe);
	vsp_encoder_model enc (.pclk, .presetn, .hs_out_n(delayed_hsync_out_n), .hs_oe(delayed_hsync_oe),
		.vs_out_n(delayed_vsync_out_n), .vs_oe(delayed_vsync_oe), .hs_wire, .vs_wire(), .hs_width);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// ****************************************
	// Expected values
	// ****************************************
	function automatic logic [4:0] lid(input int l);
		if (l == 0) return 5'h00;
		if (l <= 4) return 5'h01;
		if (l <= 8) return 5'(l - 3);
		if (l <= 16) return 5'h06;
		if (l <= 18) return 5'(l - 10);
		if (l <= 21) return 5'h09;
		if (l <= 24) return 5'(l - 12);
		if (l <= 257) return 5'h0D;
		if (l <= 259) return 5'(l - 244);
		if (l <= 261) return 5'h10;
		if (l == 262) return 5'h11;
		if (l <= 307) return 5'h12;
		return 5'(l - 289);
	endfunction
	function automatic logic vb(input logic pal, input logic odd, input int l);
		if (pal) return !(l <= (odd ? 22 : 21) || l == (odd ? 312 : 310) || l == 311);
		return !(l <= (odd ? 6 : 5) || (l >= 260 && l <= (odd ? 262 : 261)));
	endfunction
	function automatic logic bb(input logic pal, input logic [1:0] f, input int l);
		if (!pal) return !(l <= (f[0] ? 6 : 5) || (l >= (f[0] ? 260 : 259) && l <= (f[0] ? 262 : 261)));
		case (f)
			2'd0: return !(l <= 5 || (l >= 309 && l <= 311));
			2'd1: return !(l <= 5 || l >= 309);
			2'd2: return !(l <= 4 || l == 310 || l == 311);
			default: return !(l <= 6 || l >= 310);
		endcase
	endfunction
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Waits on pready with no limit; a stuck bus ends only through the bench timeout
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, r, e);
	endtask
	task automatic href;
		@(posedge pclk);
		hsync_drv_n <= 1'b0;
		// Two low cycles, so the pin filter sees stages two and three agree
		repeat (2) @(posedge pclk);
		hsync_drv_n <= 1'b1;
	endtask
	// Vertical edge together with horizontal edge starts the first field
	task automatic resync;
		@(posedge pclk);
		hsync_drv_n <= 1'b0;
		vsync_drv_n <= 1'b0;
		@(posedge pclk);
		hsync_drv_n <= 1'b1;
		vsync_drv_n <= 1'b1;
		repeat (64) @(posedge pclk);
		href();
	endtask
	// Samples mid-line only, where counters and decoded strobes have settled
	task automatic scan(input logic pal, input int n);
		int l;
		logic [2:0] f;
		logic hb;
		repeat (n) begin
			apb(1'b0, OFS_POSITION, 32'h0000_0000, r, e);
			l = int'(r[25:16]);
			f = r[30:28];
			if (r[11:0] > 12'h003 && r[11:0] < 12'h03C) begin
				chk("line range", l <= (pal ? (f[0] ? 312 : 311) : (f[0] ? 262 : 261)), 1);
				chk("vert blank", vert_blank_n, vb(pal, f[0], l));
				chk("burst blank", burst_blank_n, bb(pal, f[1:0], l));
				chk("line ident", line_ident, lid(l));
				chk("field flag", field_flag, f[0]);
				chk("line match", line_match_strobe, l == 5);
				chk("field match", field_match_strobe, f == 3'd0);
				hb = !(r[11:0] >= 12'h014 && r[11:0] <= 12'h038);
				chk("horiz blank", horiz_blank_n, hb);
				chk("mixed blank", mixed_blank_n, hb && vb(pal, f[0], l));
				chk("active video", active_video_out, r[11:0] >= 12'h010 && r[11:0] <= 12'h03C);
				chk("burst gate", burst_gate_strobe, r[11:0] >= 12'h002 && r[11:0] < 12'h012);
				chk("pixel match", pixel_match_strobe, r[11:0] == 12'h020);
				chk("vsync pin", delayed_vsync_out_n, l != 0);
			end
			// Step of 34 clocks against the 66-clock line, so samples walk across every second pixel
			repeat (31) @(posedge pclk);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ****************************************
	// Timeout and main sequence
	// ****************************************
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_total++;
			stop_test();
		end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, trs_strobe, trs_eav, trs_field} = '0;
		{clk_en, hsync_drv_n, vsync_drv_n} = 3'b111;
		presetn = 1'b0;
		err_total = 0;
		n_checks = 0;
		cyc = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ofs[i]) begin
			apb(1'b0, ofs[i], 32'h0000_0000, r, e);
			chk("reset value", r, rstv[i]);
		end
		apb(1'b0, 8'h24, 32'h0000_0000, r, e);
		chk("unmapped error", e, 1);
		chk("unmapped data", r, 0);
		wr(OFS_CTRL, 32'h0000_0022);
		#1;
		chk("hsync oe", delayed_hsync_oe, 0);
		chk("hsync pin", hs_wire, 1);
		wr(OFS_LINE_LEN, 32'h0000_0042);
		wr(OFS_BURST_POS, 32'h0000_0002);
		// Restart the line first, so the new span opens from its own start
		href();
		wr(OFS_SAV_POS, 32'h0000_0014);
		wr(OFS_EAV_POS, 32'h0000_0038);
		wr(OFS_GRAB_FL, 32'h0000_0005);
		wr(OFS_GRAB_PIX, 32'h0000_0020);
		for (int s = 0; s < 3; s += 2) begin
			wr(OFS_CTRL, 32'(s));
			href();
			repeat (4) @(posedge pclk);
			apb(1'b0, OFS_POSITION, 32'h0000_0000, r, e);
			chk("pixel restart", r[11:0] < 12'h00E, 1);
		end
		resync();
		scan(1'b0, 1050);
		wr(OFS_CTRL, 32'h0000_0006);
		resync();
		scan(1'b1, 1240);
		chk("hsync width", hs_width, 64);
		wr(OFS_CTRL, 32'h0000_0046);
		repeat (3) @(posedge pclk);
		chk("grab all line", line_match_strobe, 1);
		chk("grab all field", field_match_strobe, 1);
		stop_test();
	end
endmodule // video_sync_pulse_generator_test
`default_nettype wire
